// *** drc_defs.svh ***
// offsets, field positions, reset values and limits of the report block
`ifndef DRC_DEFS_SVH
`define DRC_DEFS_SVH

`define DRC_OFF_CTRL 8'h00
`define DRC_OFF_STATUS 8'h04
`define DRC_OFF_CFG_BASIC 8'h08
`define DRC_OFF_CFG_PATH 8'h0c

`define DRC_CTRL_EN_BIT 0
`define DRC_CTRL_LOCAL_BIT 1
`define DRC_CTRL_RESET 2'h1
`define DRC_STAT_ERR_BIT 8
`define DRC_STAT_CLR_BYTE 1

`define DRC_RESP_OKAY 2'h0
`define DRC_RESP_SLVERR 2'h2

`define DRC_TYPE_BASIC 2'h0
`define DRC_TYPE_PATH 2'h1
`define DRC_TYPE_EXT 2'h2
`define DRC_TYPE_STATUS 2'h3

`define DRC_SRC_DECODED 2'h0
`define DRC_SRC_STATUS 2'h1

`define DRC_BASIC_LEN 6'h0b
`define DRC_PATH_LEN 6'h1b
`define DRC_CNT_MAX 6'h3f
`define DRC_B_TYPE 10:9
`define DRC_B_MODE 8
`define DRC_B_SRC 7:6
`define DRC_B_PRE 5:3
`define DRC_B_GAP 2:0
`define DRC_P_TYPE 26:25
`define DRC_P_SEL 22:19
`define DRC_P_RXINH 18:11
`define DRC_P_TXINH 10:3
`define DRC_P_SKEW 2:0
`define DRC_CFG_RESET 32'h0

`define DRC_MIN_OCT 3
`define DRC_MAX_OCT 300

`endif

// *** drc_pkg.sv ***
// types shared by the receive report and configuration block
package drc_pkg;

  typedef enum logic [3:0] {
    ST_IDLE, ST_SD, ST_DATA, ST_TERM_HI, ST_TERM_LO,
    ST_ERR_LO, ST_ERR_HI, ST_HOLD
  } drc_state_t;

  typedef struct packed {
    logic op_mode;
    logic [1:0] rpt_src;
    logic [2:0] pre_ext;
    logic [2:0] gap_ext;
    logic [3:0] rx_sel;
    logic [7:0] rx_inh;
    logic [7:0] tx_inh;
    logic [2:0] skew_ext;
  } drc_cfg_t;

  typedef struct packed {
    logic sig_detect;
    logic sd_match;
    logic bit_valid;
    logic bit_val;
    logic ed_match;
    logic sym_err;
  } drc_dec_t;

endpackage

// *** drc_top.sv ***
// receive report sequencer and configuration decoder of the line interface
//
// Contract
// - activity line high enables a falling report line to start a report.
// - each reported bit changes after report clock rise, before fall.
// - bits last one clock cycle; last replaced by high then low phase.
// - termination within eight reports after data bit 8N, N 3..300.
// - final phase raises line; no new report until activity ends.
// - symbol, sequence and octet alignment faults are errors; local clock.
// - error before start-delimiter phase starts that phase at once.
// - error during start-delimiter phase ends it without a match.
// - later error: line low after rise, high after following fall.
// - after error steps go straight to the final phase.
// - configuration fields arrive in order, integers MSB first.
// - first two bits select basic, path, extendible, status message.
// - mode 0 full duplex with auto activation, 1 half duplex; reset 0.
// - nonzero report source disables transmit, forces full duplex.
// - source codes decoded, status, near loopback, far loopback.
// - three-bit preamble extension 0..7, reset zero.
// - three-bit gap extension 0..7, reset zero.
// - path message: two zero bits then four-bit medium selection.
// - codes 1000..1111 prefer medium code minus 7.
// - eight receive inhibit bits, channels 1..8, reset zero.
// - eight transmit inhibit bits, channels 1..8, reset zero.
// - three-bit skew gap extension 0..7, reset zero.
// - extendible messages share the basic structure, coding free.
// - status invocation with status source requests a status report.
//
// Added by the designer: the address map and the AXI4-Lite interface to the registers.
`include "drc_defs.svh"

module drc_top #(
  parameter int ADDR_W = 8,
  parameter int MIN_OCT = `DRC_MIN_OCT,
  parameter int MAX_OCT = `DRC_MAX_OCT
) (
  input wire logic clk, // 20 mhz system clock
  input wire logic resetn, // async reset, active low
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte lanes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic rec_clk, // recovered receive clock pin
  input wire logic local_tx_clock, // local transmit clock pin
  input wire drc_pkg::drc_dec_t dec, // decoder events
  input wire logic dte_tx_active, // transmission service in progress
  input wire logic dte_reset, // reset service pulse
  input wire logic cfg_active, // configuration service active
  input wire logic cfg_bit_valid, // configuration bit strobe
  input wire logic cfg_bit, // configuration bit value
  output logic rx_report_clock, // report clock to terminal
  output logic rx_report_line, // report data line
  output logic rx_activity_line, // media activity line
  output drc_pkg::drc_cfg_t cfg, // applied configuration
  output logic tx_disable, // transmit disabled on all media
  output logic full_duplex, // effective interface mode
  output logic status_req // build status report pulse
);
  import drc_pkg::*;

  // pin synchronisers and report clock edges
  logic rc_s1_r, rc_s2_r, lt_s1_r, lt_s2_r, sel_d_r, rise_r, fall_r;
  logic use_local_r;
  wire sel_clk = use_local_r ? lt_s2_r : rc_s2_r;
  wire rise_w = sel_clk & ~sel_d_r;
  wire fall_w = ~sel_clk & sel_d_r;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rc_s1_r <= 1'b0;
      rc_s2_r <= 1'b0;
      lt_s1_r <= 1'b0;
      lt_s2_r <= 1'b0;
      sel_d_r <= 1'b0;
      rise_r <= 1'b0;
      fall_r <= 1'b0;
      rx_report_clock <= 1'b0;
    end else begin
      rc_s1_r <= rec_clk;
      rc_s2_r <= rc_s1_r;
      lt_s1_r <= local_tx_clock;
      lt_s2_r <= lt_s1_r;
      sel_d_r <= sel_clk;
      rise_r <= rise_w;
      fall_r <= fall_w;
      rx_report_clock <= sel_clk;
    end
  end

  // register file state
  logic [1:0] ctrl_r;
  logic err_sticky_r;
  drc_cfg_t cfg_r;

  // activity: decoder signaling, or own transmission when auto activated
  wire auto_act = ~cfg_r.op_mode | (cfg_r.rpt_src != `DRC_SRC_DECODED);
  wire act_w = dec.sig_detect | (auto_act & dte_tx_active);

  // report sequencer
  drc_state_t st_r, st_nxt;
  logic line_r, line_nxt, err_r, sd_pend_r, ed_pend_r, pend_v_r, pend_bit_r;
  logic [2:0] bitcnt_r;
  logic [8:0] octcnt_r;
  wire rpt_en = ctrl_r[`DRC_CTRL_EN_BIT];
  wire ed_bad = (bitcnt_r != 3'h0) | (octcnt_r < 9'(MIN_OCT));
  wire too_long = (octcnt_r > 9'(MAX_OCT));
  // misaligned or too-short end delimiter (fewer than MIN_OCT octets) with the bit slot drained
  wire ed_err = (st_r == ST_DATA) & ed_pend_r & ~pend_v_r & ed_bad;
  wire err_evt = dec.sym_err | too_long | ed_err;
  wire in_rpt = (st_r != ST_IDLE) & (st_r != ST_HOLD);
  wire take_bit = (st_r == ST_DATA) & rise_r & pend_v_r & ~err_r;

  always_comb begin
    st_nxt = st_r;
    line_nxt = line_r;
    unique case (st_r)
      ST_IDLE: begin
        if (act_w & rpt_en & (dec.sig_detect | err_evt) & rise_r) begin
          line_nxt = 1'b0;
          st_nxt = ST_SD;
        end
      end
      ST_SD: begin
        if (fall_r & (sd_pend_r | err_r)) begin
          line_nxt = ~line_r;
          st_nxt = err_r ? ST_HOLD : ST_DATA;
        end
      end
      ST_DATA: begin
        if (rise_r) begin
          if (err_r) begin
            line_nxt = 1'b0;
            st_nxt = ST_ERR_LO;
          end else if (pend_v_r) begin
            line_nxt = pend_bit_r;
          end else if (ed_pend_r & ed_bad) begin
            line_nxt = 1'b0;
            st_nxt = ST_ERR_LO;
          end else if (ed_pend_r) begin
            line_nxt = 1'b1;
            st_nxt = ST_TERM_HI;
          end
        end
      end
      ST_TERM_HI: begin
        if (fall_r) begin
          line_nxt = 1'b0;
          st_nxt = ST_TERM_LO;
        end
      end
      ST_TERM_LO: begin
        if (rise_r) begin
          line_nxt = 1'b1;
          st_nxt = ST_HOLD;
        end
      end
      ST_ERR_LO: begin
        if (fall_r) begin
          line_nxt = 1'b1;
          st_nxt = ST_HOLD;
        end
      end
      ST_ERR_HI: begin
        line_nxt = 1'b1;
        st_nxt = ST_HOLD;
      end
      ST_HOLD: begin
        line_nxt = 1'b1;
        if (!act_w) begin
          st_nxt = ST_IDLE;
        end
      end
    endcase
    if (in_rpt & ~act_w) begin
      line_nxt = 1'b1;
      st_nxt = ST_IDLE;
    end
    if (dte_reset) begin
      line_nxt = 1'b1;
      st_nxt = ST_IDLE;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= ST_IDLE;
      line_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      line_r <= line_nxt;
    end
  end

  // pending events from the decoder
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      err_r <= 1'b0;
      sd_pend_r <= 1'b0;
      ed_pend_r <= 1'b0;
      pend_v_r <= 1'b0;
      pend_bit_r <= 1'b0;
      use_local_r <= 1'b0;
    end else if (st_nxt == ST_IDLE && st_r != ST_IDLE) begin
      err_r <= 1'b0;
      sd_pend_r <= 1'b0;
      ed_pend_r <= 1'b0;
      pend_v_r <= 1'b0;
      use_local_r <= ctrl_r[`DRC_CTRL_LOCAL_BIT];
    end else begin
      if (err_evt & act_w) begin
        err_r <= 1'b1;
      end
      if (dec.sd_match) begin
        sd_pend_r <= 1'b1;
      end
      if (dec.ed_match & (st_r == ST_DATA)) begin
        ed_pend_r <= 1'b1;
      end
      if (dec.bit_valid & (st_r == ST_DATA)) begin
        pend_v_r <= 1'b1;
        pend_bit_r <= dec.bit_val;
      end else if (take_bit) begin
        pend_v_r <= 1'b0;
      end
      // keep the report clock alive when recovery is lost
      if (ctrl_r[`DRC_CTRL_LOCAL_BIT] | (err_evt & ~dec.sig_detect)) begin
        use_local_r <= 1'b1;
      end
    end
  end

  // data bit and octet counters of the data phase
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bitcnt_r <= 3'h0;
      octcnt_r <= 9'h000;
    end else if (st_r != ST_DATA) begin
      bitcnt_r <= 3'h0;
      octcnt_r <= 9'h000;
    end else if (take_bit) begin
      bitcnt_r <= bitcnt_r + 3'h1;
      if (bitcnt_r == 3'h7 && !too_long) begin
        octcnt_r <= octcnt_r + 9'h001;
      end
    end
  end

  // configuration message shift-in, msb first
  logic [26:0] sr_r;
  logic [5:0] cnt_r;
  logic cfg_d_r;
  wire cfg_end = cfg_d_r & ~cfg_active;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sr_r <= 27'h0;
      cnt_r <= 6'h00;
      cfg_d_r <= 1'b0;
    end else begin
      cfg_d_r <= cfg_active;
      if (!cfg_active) begin
        cnt_r <= 6'h00;
      end else if (cfg_bit_valid) begin
        sr_r <= {sr_r[25:0], cfg_bit};
        if (cnt_r != `DRC_CNT_MAX) begin
          cnt_r <= cnt_r + 6'h01;
        end
      end
    end
  end

  wire is_basic = (cnt_r == `DRC_BASIC_LEN) &
                  (sr_r[`DRC_B_TYPE] == `DRC_TYPE_BASIC);
  wire is_path = (cnt_r == `DRC_PATH_LEN) &
                 (sr_r[`DRC_P_TYPE] == `DRC_TYPE_PATH);
  wire is_stat = (cnt_r == `DRC_BASIC_LEN) &
                 (sr_r[`DRC_B_TYPE] == `DRC_TYPE_STATUS);

  drc_cfg_t cfg_nxt;
  always_comb begin
    cfg_nxt = cfg_r;
    if (cfg_end & is_basic) begin
      cfg_nxt.op_mode = sr_r[`DRC_B_MODE];
      cfg_nxt.rpt_src = sr_r[`DRC_B_SRC];
      cfg_nxt.pre_ext = sr_r[`DRC_B_PRE];
      cfg_nxt.gap_ext = sr_r[`DRC_B_GAP];
    end
    if (cfg_end & is_path) begin
      cfg_nxt.rx_sel = sr_r[`DRC_P_SEL];
      cfg_nxt.rx_inh = sr_r[`DRC_P_RXINH];
      cfg_nxt.tx_inh = sr_r[`DRC_P_TXINH];
      cfg_nxt.skew_ext = sr_r[`DRC_P_SKEW];
    end
    if (dte_reset) begin
      cfg_nxt = `DRC_CFG_RESET;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg_r <= `DRC_CFG_RESET;
      tx_disable <= 1'b0;
      full_duplex <= 1'b1;
      status_req <= 1'b0;
      rx_activity_line <= 1'b0;
    end else begin
      cfg_r <= cfg_nxt;
      tx_disable <= (cfg_nxt.rpt_src != `DRC_SRC_DECODED);
      full_duplex <= ~cfg_nxt.op_mode |
                     (cfg_nxt.rpt_src != `DRC_SRC_DECODED);
      status_req <= cfg_end & is_stat &
                    (cfg_r.rpt_src == `DRC_SRC_STATUS);
      rx_activity_line <= act_w;
    end
  end

  assign cfg = cfg_r;
  assign rx_report_line = line_r;

  // register bus slave
  function automatic logic [3:0] reg_hit(input logic [ADDR_W-1:0] a);
    reg_hit = {a == ADDR_W'(`DRC_OFF_CFG_PATH),
               a == ADDR_W'(`DRC_OFF_CFG_BASIC),
               a == ADDR_W'(`DRC_OFF_STATUS),
               a == ADDR_W'(`DRC_OFF_CTRL)};
  endfunction

  logic aw_full_r, w_full_r, awready_r, wready_r, bvalid_r;
  logic arready_r, rvalid_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r, rdata_r;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r, rresp_r;
  wire aw_hs = s_axi_awvalid & awready_r;
  wire w_hs = s_axi_wvalid & wready_r;
  wire do_wr = aw_full_r & w_full_r & ~bvalid_r;
  wire aw_full_nxt = (aw_full_r | aw_hs) & ~do_wr;
  wire w_full_nxt = (w_full_r | w_hs) & ~do_wr;
  wire bvalid_nxt = do_wr | (bvalid_r & ~s_axi_bready);
  wire ar_hs = s_axi_arvalid & arready_r;
  wire rvalid_nxt = ar_hs | (rvalid_r & ~s_axi_rready);
  wire [3:0] whit = reg_hit(awaddr_r);
  wire [3:0] rhit = reg_hit(s_axi_araddr);
  wire clr_err = do_wr & whit[1] & wstrb_r[`DRC_STAT_CLR_BYTE] &
                 wdata_r[`DRC_STAT_ERR_BIT];
  wire [31:0] stat_w = {23'h0, err_sticky_r, 1'b0, use_local_r,
                        rx_activity_line, line_r, 4'(st_r)};
  wire [31:0] rd_w = ({32{rhit[0]}} & {30'h0, ctrl_r}) |
                     ({32{rhit[1]}} & stat_w) |
                     ({32{rhit[2]}} & {23'h0, cfg_r.op_mode,
                       cfg_r.rpt_src, cfg_r.pre_ext, cfg_r.gap_ext}) |
                     ({32{rhit[3]}} & {9'h0, cfg_r.rx_sel,
                       cfg_r.rx_inh, cfg_r.tx_inh, cfg_r.skew_ext});

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= `DRC_RESP_OKAY;
      awaddr_r <= '0;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= `DRC_RESP_OKAY;
    end else begin
      aw_full_r <= aw_full_nxt;
      w_full_r <= w_full_nxt;
      awready_r <= ~aw_full_nxt & ~bvalid_nxt;
      wready_r <= ~w_full_nxt & ~bvalid_nxt;
      bvalid_r <= bvalid_nxt;
      arready_r <= ~rvalid_nxt;
      rvalid_r <= rvalid_nxt;
      if (aw_hs) begin
        awaddr_r <= s_axi_awaddr;
      end
      if (w_hs) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (do_wr) begin
        bresp_r <= (whit == 4'h0) ? `DRC_RESP_SLVERR : `DRC_RESP_OKAY;
      end
      if (ar_hs) begin
        rdata_r <= rd_w;
        rresp_r <= (rhit == 4'h0) ? `DRC_RESP_SLVERR : `DRC_RESP_OKAY;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_r <= `DRC_CTRL_RESET;
      err_sticky_r <= 1'b0;
    end else begin
      if (do_wr & whit[0] & wstrb_r[0]) begin
        ctrl_r <= wdata_r[1:0];
      end
      // a new error wins over a clear in the same cycle
      if (err_evt & act_w) begin
        err_sticky_r <= 1'b1;
      end else if (clr_err) begin
        err_sticky_r <= 1'b0;
      end
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_bit_on_rise;
    ($past(st_r) == ST_DATA) && (st_r == ST_DATA) && $changed(line_r)
      |-> $past(rise_r);
  endproperty
  a_bit_on_rise: assert property (p_bit_on_rise)
    else $error("report bit changed away from a clock rise");

  property p_term_pair;
    (st_r == ST_TERM_HI) && fall_r && act_w && !dte_reset
      |=> !line_r && st_r == ST_TERM_LO;
  endproperty
  a_term_pair: assert property (p_term_pair)
    else $error("terminating pair did not fall on the clock fall");

  property p_no_restart;
    (st_r == ST_IDLE) && $past(st_r) == ST_HOLD && !$past(dte_reset)
      |-> !$past(act_w);
  endproperty
  a_no_restart: assert property (p_no_restart)
    else $error("report released while activity still present");

  property p_err_latched;
    dec.sym_err && act_w && in_rpt && !dte_reset && st_nxt != ST_IDLE
      |=> err_r;
  endproperty
  a_err_latched: assert property (p_err_latched)
    else $error("symbol error not recorded");

  property p_err_in_data;
    (st_r == ST_DATA) && err_r && rise_r && act_w && !dte_reset
      |=> !line_r && st_r == ST_ERR_LO;
  endproperty
  a_err_in_data: assert property (p_err_in_data)
    else $error("error in data phase did not lower the line");

  property p_err_to_final;
    (st_r == ST_ERR_LO) && fall_r && act_w && !dte_reset
      |=> line_r && st_r == ST_HOLD;
  endproperty
  a_err_to_final: assert property (p_err_to_final)
    else $error("error sequence did not reach the final phase");

  property p_sd_error;
    (st_r == ST_SD) && err_r && fall_r && act_w && !dte_reset
      |=> st_r == ST_HOLD && line_r != $past(line_r);
  endproperty
  a_sd_error: assert property (p_sd_error)
    else $error("start phase not concluded on error");

  property p_tx_disable;
    (tx_disable == (cfg_r.rpt_src != 2'h0)) &&
      (full_duplex == (!cfg_r.op_mode || cfg_r.rpt_src != 2'h0));
  endproperty
  a_tx_disable: assert property (p_tx_disable)
    else $error("report source does not steer transmit disable");

  property p_cfg_at_end;
    $changed(cfg_r) |-> $past(cfg_end) || $past(dte_reset);
  endproperty
  a_cfg_at_end: assert property (p_cfg_at_end)
    else $error("configuration changed before message end");

  property p_status_req;
    status_req |-> $past(cfg_r.rpt_src) == 2'h1 && $past(cfg_end);
  endproperty
  a_status_req: assert property (p_status_req)
    else $error("status request without status source");

  c_term: cover property (st_r == ST_TERM_LO ##[1:20] st_r == ST_HOLD);
  c_err_data: cover property (st_r == ST_ERR_LO);
  c_path_cfg: cover property (cfg_end && is_path);
  c_status: cover property (status_req);

endmodule

// *** drc_dte_model.sv ***
// terminal-side model that sends configuration messages bit by bit
module drc_dte_model (
  input wire logic clk, // system clock
  output logic cfg_active, // configuration service active
  output logic cfg_bit_valid, // bit strobe
  output logic cfg_bit // bit value
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cfg_active = 1'h0;
    cfg_bit_valid = 1'h0;
    cfg_bit = 1'h0;
  end
  // first bit sent is the top one of the n given
  task automatic send(input logic [26:0] b, input int n);
    @(posedge clk);
    cfg_active <= 1'h1;
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge clk);
      cfg_bit_valid <= 1'h1;
      cfg_bit <= b[i];
    end
    @(posedge clk);
    cfg_bit_valid <= 1'h0;
    cfg_bit <= ~cfg_bit;
    cfg_active <= 1'h0;
    @(posedge clk);
  endtask
endmodule

// *** tb.sv ***
// self-checking bench of the report sequencer and configuration decoder
`include "drc_defs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import drc_pkg::*;
  typedef struct packed {
    logic [26:0] b;
    logic [5:0] n;
    drc_cfg_t e;
  } drc_row_t;
  function automatic logic [26:0] bm(logic [1:0] t, logic [8:0] f);
    return {16'h0, t, f};
  endfunction
  logic clk, resetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, rec_clk, ltc, lk_run, dte_tx;
  logic dte_rst, cact, cbv, cb, rclk, rline, ract, txd, fd, sreq;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rr;
  drc_dec_t dec;
  drc_cfg_t cfg;
  int failures, samples_checked, pulses;
  drc_row_t rows [7] = '{
    '{bm(2'h0, 9'h13d), 6'h0b, 32'h9e800000},
    '{{2'h1, 2'h0, 4'ha, 8'ha5, 8'h3c, 3'h6}, 6'h1b, 32'h9ed529e6},
    '{bm(2'h0, 9'h181), 6'h0b, 32'hc0d529e6},
    '{bm(2'h0, 9'h0d8), 6'h0b, 32'h6c5529e6},
    '{bm(2'h2, 9'h000), 6'h0b, 32'h6c5529e6},
    '{bm(2'h0, 9'h040), 6'h0a, 32'h6c5529e6},
    '{bm(2'h0, 9'h040), 6'h0b, 32'h205529e6}};
  drc_dte_model m (.clk(clk), .cfg_active(cact), .cfg_bit_valid(cbv),
    .cfg_bit(cb));
  drc_top dut (.clk(clk), .resetn(resetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .rec_clk(rec_clk), .local_tx_clock(ltc),
    .dec(dec), .dte_tx_active(dte_tx), .dte_reset(dte_rst),
    .cfg_active(cact), .cfg_bit_valid(cbv), .cfg_bit(cb),
    .rx_report_clock(rclk), .rx_report_line(rline),
    .rx_activity_line(ract), .cfg(cfg), .tx_disable(txd),
    .full_duplex(fd), .status_req(sreq));
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  // recovered clock stands low outside frames, local one runs free
  initial begin
    #207;
    forever #200 rec_clk = lk_run ? ~rec_clk : 1'h0;
  end
  initial begin
    #113;
    forever #200 ltc = ~ltc;
  end
  always @(posedge clk) if (sreq === 1'h1) pulses++;
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic results();
    if (failures == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic axr(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge clk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    while (rvalid !== 1'h1) @(posedge clk);
    rd = rdata;
    rr = rresp;
    rready <= 1'h0;
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s);
    logic ad, wd;
    ad = 1'h0;
    wd = 1'h0;
    @(posedge clk);
    {awaddr, wdata, wstrb} <= {a, d, s};
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(posedge clk);
      if (awready === 1'h1 && !ad) begin
        awvalid <= 1'h0;
        ad = 1'h1;
      end
      if (wready === 1'h1 && !wd) begin
        wvalid <= 1'h0;
        wd = 1'h1;
      end
    end while (!(ad && wd));
    while (bvalid !== 1'h1) @(posedge clk);
    rr = bresp;
    bready <= 1'h0;
  endtask
  task automatic wt(ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk(s, v);
  endtask
  // one frame: start, nb bits of pat from the top, end delimiter
  task automatic frame(input int nb, input logic [23:0] pat);
    dec.sig_detect <= 1'h1;
    wt(rline, 1'h0);
    dec.sd_match <= 1'h1;
    @(posedge clk);
    dec.sd_match <= 1'h0;
    wt(rline, 1'h1);
    for (int i = 23; i >= 24 - nb; i--) begin
      dec.bit_valid <= 1'h1;
      dec.bit_val <= pat[i];
      @(posedge clk);
      dec.bit_valid <= 1'h0;
      do @(posedge clk); while (rclk !== 1'h0);
      do @(posedge clk); while (rclk !== 1'h1);
      @(posedge clk);
      chk(rline, pat[i]);
    end
    dec.ed_match <= 1'h1;
    @(posedge clk);
    dec.ed_match <= 1'h0;
  endtask
  initial begin
    {resetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {rec_clk, ltc, lk_run, dte_tx, dte_rst} = '0;
    dec = '0;
    {failures, samples_checked, pulses} = '0;
    repeat (8) @(posedge clk);
    resetn <= 1'h1;
    @(posedge clk);
    chk(cfg, `DRC_CFG_RESET);
    chk({rline, fd, txd}, 3'h6);
    for (int i = 0; i < 7; i++) begin
      m.send(rows[i].b, rows[i].n);
      repeat (3) @(posedge clk);
      chk(cfg, rows[i].e);
      chk(txd, rows[i].e.rpt_src != 2'h0);
      chk(fd, !rows[i].e.op_mode || rows[i].e.rpt_src != 2'h0);
      axr(`DRC_OFF_CFG_BASIC);
      chk(rd, {23'h0, rows[i].e[31:23]});
      axr(`DRC_OFF_CFG_PATH);
      chk(rd, {9'h0, rows[i].e[22:0]});
    end
    m.send(bm(2'h3, 9'h0), 11);
    repeat (3) @(posedge clk);
    chk(pulses, 1);
    @(posedge clk);
    dte_rst <= 1'h1;
    @(posedge clk);
    dte_rst <= 1'h0;
    repeat (2) @(posedge clk);
    chk(cfg, `DRC_CFG_RESET);
    m.send(bm(2'h3, 9'h0), 11);
    repeat (3) @(posedge clk);
    chk(pulses, 1);
    dte_tx <= 1'h1;
    wt(ract, 1'h1);
    dte_tx <= 1'h0;
    wt(ract, 1'h0);
    axr(8'h10);
    chk(rr, `DRC_RESP_SLVERR);
    chk(rd, 32'h0);
    @(posedge clk);
    dec.sig_detect <= 1'h1;
    lk_run <= 1'h1;
    wt(ract, 1'h1);
    wt(rline, 1'h0);
    @(posedge clk);
    dec.sym_err <= 1'h1;
    @(posedge clk);
    dec.sym_err <= 1'h0;
    wt(rline, 1'h1);
    repeat (40) @(posedge clk);
    chk(rline, 1'h1);
    axr(`DRC_OFF_STATUS);
    chk({rd[8], rd[3:0]}, 5'h17);
    axw(`DRC_OFF_STATUS, 32'h100, 4'h2);
    axr(`DRC_OFF_STATUS);
    chk({rr, rd[8]}, 3'h0);
    dec.sig_detect <= 1'h0;
    wt(ract, 1'h0);
    lk_run <= 1'h0;
    repeat (20) @(posedge clk);
    lk_run <= 1'h1;
    frame(24, 24'h5a3c96);
    wt(rline, 1'h1);
    wt(rline, 1'h0);
    wt(rline, 1'h1);
    axr(`DRC_OFF_STATUS);
    chk(rd[8:0], 9'h037);
    axw(`DRC_OFF_CTRL, 32'h3, 4'h1);
    chk(rr, `DRC_RESP_OKAY);
    dec.sig_detect <= 1'h0;
    lk_run <= 1'h0;
    wt(ract, 1'h0);
    repeat (20) @(posedge clk);
    // recovered clock stays still: the local clock must carry the report
    frame(20, 24'h5a3c96);
    wt(rline, 1'h0);
    wt(rline, 1'h1);
    axr(`DRC_OFF_STATUS);
    chk(rd[8:0], 9'h177);
    dec.sig_detect <= 1'h0;
    wt(ract, 1'h0);
    results();
  end
  initial begin
    #500000;
    failures++;
    results();
  end
endmodule
